// ===== rtl/sdc_top.sv
// multichannel sinc3 decimator with clock-source select and reference bits
// assumes modulator bits arrive synchronous to clk, sampled on the divided strobe
`timescale 1ns/1ps
`default_nettype none
module sdc_top (
  input  wire logic                              clk,            // converter clock
  input  wire logic                              rst_n,          // sync reset, active low
  input  wire logic                              start,          // conversion start level
  input  wire logic                              low_power,      // 1 = low-power mode
  input  wire logic [sdc_pkg::DR_W-1:0]          decimation_ratio_field, // global ratio
  input  wire logic [sdc_pkg::NUM_CH-1:0]        mod_bits,       // modulator bit per channel
  input  wire logic                              clock_source_select_pin, // 1 = internal
  input  wire logic                              clk_out_en,     // clock-output enable bit
  input  wire logic                              osc_in,         // internal oscillator level
  input  wire logic                              clk_pin_i,      // clock pin input level
  input  wire logic                              reference_buffer_power_bit, // 1 = buf on
  input  wire logic                              reference_level_select, // 1 = 4V
  output logic                                   clk_pin_o,      // clock pin drive value
  output logic                                   clk_pin_oe,     // clock pin output enable
  output logic                                   conv_clk_q,     // selected converter clock
  output logic                                   refbuf_pd_q,    // 1 = buffer off, ext ref
  output logic                                   reference_level_select_q,      // 1 = 4V reference
  output logic                                   mod_strobe_q,   // modulator sample strobe
  output logic                                   data_ready_q,   // one-cycle new-data pulse
  output logic [sdc_pkg::NUM_CH*sdc_pkg::DATA_W-1:0] data_q,     // channel words, ch0 low
  output logic [4:0]                             eff_bits_q      // effective bits of result
);
  logic [sdc_pkg::DIV_W-1:0] div_q;
  logic [sdc_pkg::CNT_W-1:0] dec_cnt_q;
  logic [1:0]                settle_q;
  logic                      start_q, restart;
  logic                      dec_pt;
  logic [sdc_pkg::DR_W-1:0]  dr_q;
  logic [sdc_pkg::NUM_CH*sdc_pkg::DATA_W-1:0] words;
  logic [sdc_pkg::DIV_W-1:0] div_max;

  assign restart = start && !start_q;
  assign div_max = low_power ? sdc_pkg::DIV_W'(sdc_pkg::MOD_DIV_LP - 1)
                             : sdc_pkg::DIV_W'(sdc_pkg::MOD_DIV_HR - 1);
  assign dec_pt  = (dec_cnt_q == sdc_pkg::sdc_ratio(dr_q) - 16'h0001);

  // start edge detect and ratio capture at restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      dr_q    <= sdc_pkg::DR_RST;
    end else begin
      start_q <= start;
      if (restart) dr_q <= decimation_ratio_field;
    end
  end

  // modulator clock divider
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      div_q        <= '0;
      mod_strobe_q <= 1'b0;
    end else begin
      mod_strobe_q <= (div_q == div_max) && start;
      div_q        <= (div_q >= div_max) ? '0 : div_q + 4'h1;
    end
  end

  // decimation counter and settling count
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      dec_cnt_q <= '0;
      settle_q  <= 2'h0;
    end else if (mod_strobe_q) begin
      dec_cnt_q <= dec_pt ? '0 : dec_cnt_q + 16'h0001;
      if (dec_pt && settle_q != 2'(sdc_pkg::SETTLE_PER)) settle_q <= settle_q + 2'h1;
    end
  end

  // per-channel filters
  genvar g;
  generate
    for (g = 0; g < sdc_pkg::NUM_CH; g++) begin : g_ch
      sdc_chan u_chan (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (restart),
        .bit_vld (mod_strobe_q),
        .bit_in  (mod_bits[g]),
        .dec_vld (dec_pt),
        .shift   (sdc_pkg::sdc_shift(dr_q)),
        .word_q  (words[g*sdc_pkg::DATA_W +: sdc_pkg::DATA_W])
      );
      // a channel word moves only at a decimation point or a restart
      // guards against a comb stage that updates on every sample
      AST_WORD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(mod_strobe_q && dec_pt) && !restart |=> $stable(words[g*sdc_pkg::DATA_W +: sdc_pkg::DATA_W]))
        else $error("channel word moved between decimation points");
    end
  endgenerate

  // ready pulse once settled; words sampled one cycle after filter update
  logic upd_q;
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      upd_q        <= 1'b0;
      data_ready_q <= 1'b0;
      data_q       <= '0;
      eff_bits_q   <= 5'h18;
    end else begin
      upd_q        <= mod_strobe_q && dec_pt && settle_q == 2'(sdc_pkg::SETTLE_PER - 1)
                      || mod_strobe_q && dec_pt && settle_q == 2'(sdc_pkg::SETTLE_PER);
      data_ready_q <= upd_q;
      if (upd_q) data_q <= words;
      eff_bits_q   <= (dr_q == 3'h0) ? 5'h11 : (dr_q == 3'h1) ? 5'h13 : 5'h18;
    end
  end

  // clock source select and pin direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b0;
      conv_clk_q <= 1'b0;
    end else if (!clock_source_select_pin) begin
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b0;
      conv_clk_q <= clk_pin_i;
    end else begin
      clk_pin_o  <= clk_out_en ? osc_in : 1'b0;
      clk_pin_oe <= clk_out_en;
      conv_clk_q <= osc_in;
    end
  end

  // reference configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refbuf_pd_q <= sdc_pkg::REFBUF_PD_RST;
      reference_level_select_q   <= sdc_pkg::VREF_HI_RST;
    end else begin
      refbuf_pd_q <= !reference_buffer_power_bit;
      reference_level_select_q   <= reference_level_select;
    end
  end

  // settling count never exceeds its limit and ready needs prior settling
  AST_SETTLE_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    settle_q <= 2'(sdc_pkg::SETTLE_PER)) else $error("settle count overflow");
  AST_READY_AFTER_SETTLE: assert property (@(posedge clk) disable iff (!rst_n)
    data_ready_q |-> $past(settle_q, 2) >= 2'(sdc_pkg::SETTLE_PER - 1))
    else $error("data ready before settling");
  AST_RESTART_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> !data_ready_q && settle_q == 2'h0) else $error("restart did not clear");
  AST_DIV_HR: assert property (@(posedge clk) disable iff (!rst_n || restart)
    mod_strobe_q && !low_power ##1 !low_power[*3] |=> mod_strobe_q || !$past(start))
    else $error("high-res strobe period wrong");
  AST_STROBE_GAP: assert property (@(posedge clk) disable iff (!rst_n)
    mod_strobe_q |=> !mod_strobe_q ##1 !mod_strobe_q ##1 !mod_strobe_q)
    else $error("modulator strobe too frequent");
  AST_PIN_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
    !clock_source_select_pin |=> !clk_pin_oe) else $error("pin driven with external clock");
  AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    clock_source_select_pin |=> clk_pin_oe == $past(clk_out_en)) else $error("pin enable wrong");
  AST_REF_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 reference_level_select_q == $past(reference_level_select)) else $error("reference level wrong");
  AST_EFF_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    dr_q == 3'h0 && !restart |=> eff_bits_q == 5'h11) else $error("resolution wrong");
  AST_REFBUF: assert property (@(posedge clk)
    $rose(rst_n) |-> refbuf_pd_q) else $error("not external reference after reset");

  // low-power strobe spacing is eight converter clocks while the mode holds
  // a mode change inside the window legitimately stretches or cuts the period
  AST_DIV_LP: assert property (@(posedge clk) disable iff (!rst_n || restart)
    mod_strobe_q && low_power ##1 low_power[*7] |=> mod_strobe_q || !$past(start))
    else $error("low-power strobe period wrong");

  // no modulator sample is taken while start is low
  // keeps idle channels from integrating stale bits
  AST_NO_STROBE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(start) |-> !mod_strobe_q) else $error("strobe while stopped");

  // the ready flag is a single-cycle pulse
  // a stretched pulse would let the host read one word twice
  AST_READY_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    data_ready_q |=> !data_ready_q) else $error("ready longer than one cycle");

  // parallel words stand until the next ready pulse or a restart
  // the host may read them at any time between pulses
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !upd_q && !restart |=> $stable(data_q)) else $error("data moved without ready");

  // the working ratio only changes on a start rise
  // a mid-run change would break the common data rate of all channels
  AST_RATIO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !restart |=> $stable(dr_q)) else $error("ratio changed without restart");

  // the start rise captures the global ratio field
  AST_RATIO_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> dr_q == $past(decimation_ratio_field)) else $error("ratio not captured");

  // the decimation counter never reaches the ratio
  // an overrun would skip a decimation point and halve the data rate
  AST_DEC_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    dec_cnt_q < sdc_pkg::sdc_ratio(dr_q)) else $error("decimation count overrun");

  // the counter steps by one per modulator sample between decimation points
  AST_DEC_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    mod_strobe_q && !dec_pt && !restart |=> dec_cnt_q == $past(dec_cnt_q) + 16'h0001)
    else $error("decimation count step wrong");

  // with the pin driven, it carries the oscillator level
  AST_PIN_OUT_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
    clock_source_select_pin && clk_out_en |=> clk_pin_o == $past(osc_in))
    else $error("pin does not carry oscillator");

  // an undriven pin shows a quiet drive value
  AST_PIN_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_pin_oe |-> !clk_pin_o) else $error("drive value while tristate");

  // select low: converter clock follows the clock pin
  AST_CLK_EXT: assert property (@(posedge clk) disable iff (!rst_n)
    !clock_source_select_pin |=> conv_clk_q == $past(clk_pin_i))
    else $error("external clock not selected");

  // select high: converter clock follows the oscillator whatever the enable bit
  AST_CLK_INT: assert property (@(posedge clk) disable iff (!rst_n)
    clock_source_select_pin |=> conv_clk_q == $past(osc_in))
    else $error("internal clock not selected");

  // buffer power-down state follows the configuration bit
  AST_REFBUF_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 refbuf_pd_q == !$past(reference_buffer_power_bit))
    else $error("buffer state wrong");

  // field 001 reports reduced resolution
  AST_EFF_19: assert property (@(posedge clk) disable iff (!rst_n)
    dr_q == 3'h1 && !restart |=> eff_bits_q == 5'h13) else $error("resolution wrong at 001");

  // fields 010 through 111 report the full word width
  AST_EFF_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    dr_q > 3'h1 && !restart |=> eff_bits_q == 5'h18) else $error("full resolution wrong");

  // a start rise empties the sample pipeline
  // no strobe, count or pending update survives the edge
  AST_RESTART_PIPE: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> !mod_strobe_q && dec_cnt_q == '0 && !upd_q)
    else $error("restart left pipeline state");

  // a start rise also clears the words already presented
  AST_RESTART_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> data_q == '0) else $error("restart left old data");
endmodule : sdc_top
`default_nettype wire

// ===== rtl/sdc_pkg.sv
// constants and functions shared by the sinc3 decimator and its channel filter
// assumes a single converter clock domain; no bus, all control on ports
package sdc_pkg;
  localparam int NUM_CH       = 8;         // channels per device
  localparam int DATA_W       = 24;        // output word width
  localparam int ACC_W        = 48;        // accumulator width, room for N^3 gain
  localparam int DR_W         = 3;         // decimation-ratio field width
  localparam int MOD_DIV_HR   = 4;         // converter clocks per modulator clock, high-res
  localparam int MOD_DIV_LP   = 8;         // converter clocks per modulator clock, low-power
  localparam int DIV_W        = 4;         // width of modulator clock divider
  localparam int SETTLE_PER   = 3;         // decimation periods until the first ready after restart
  localparam int CNT_W        = 16;        // decimation counter width
  localparam int PRE_SHIFT    = 11;        // left scaling so N=16 full scale reaches 2^23
  localparam logic [DATA_W-1:0] POS_CLIP = 24'h7FFFFF; // positive overrange code
  localparam logic [DATA_W-1:0] NEG_CLIP = 24'h800000; // negative overrange code
  localparam logic CLK_EN_RST     = 1'b0;  // clock-output enable after reset
  localparam logic REFBUF_PD_RST  = 1'b1;  // reference buffer powered down: external ref
  localparam logic VREF_HI_RST    = 1'b0;  // 2.4 V reference after reset
  localparam logic [DR_W-1:0] DR_RST = 3'h6; // decimation-ratio field after reset

  // decimation ratio N from the field: 16 << (6 - field) for 000..110, 111 reserved
  function automatic logic [CNT_W-1:0] sdc_ratio(input logic [DR_W-1:0] dr);
    logic [CNT_W-1:0] r;
    r = 16'h0010;
    if (dr == 3'h7) r = 16'h0010;
    else r = 16'h0010 << (3'h6 - dr);
    return r;
  endfunction : sdc_ratio

  // right shift applied after the fixed left scaling: 3*log2(N) - 23 + PRE_SHIFT
  // keeps the shift non-negative for the smallest ratio, so full scale maps to 2^23
  function automatic logic [5:0] sdc_shift(input logic [DR_W-1:0] dr);
    logic [5:0] s;
    s = 6'h00;
    if (dr == 3'h7) s = 6'h00;
    else s = 6'(3 * (10 - int'(dr)) - 23 + PRE_SHIFT);
    return s;
  endfunction : sdc_shift
endpackage : sdc_pkg

// ===== rtl/sdc_chan.sv
// one channel of third-order sinc decimation with clipping to 24 bits
// assumes bit_vld marks one modulator sample, dec_vld marks the end of a decimation period
`timescale 1ns/1ps
`default_nettype none
module sdc_chan (
  input  wire logic                       clk,      // converter clock
  input  wire logic                       rst_n,    // synchronous reset, active low
  input  wire logic                       restart,  // clear all accumulators
  input  wire logic                       bit_vld,  // modulator sample strobe
  input  wire logic                       bit_in,   // modulator bit, 1 = +1
  input  wire logic                       dec_vld,  // decimation point (with bit_vld)
  input  wire logic [5:0]                 shift,    // output scaling shift
  output logic      [sdc_pkg::DATA_W-1:0] word_q    // last clipped output word
);
  localparam int W = sdc_pkg::ACC_W;
  logic signed [W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
  logic signed [W-1:0] x, i3_n, c1, c2, c3, sc;

  // comb differences at the decimated rate
  always_comb begin
    x  = bit_in ? W'(1) : -W'(1);
    i3_n = i3_q + i2_q;          // integrator output including this sample
    c1 = i3_n - d1_q;
    c2 = c1 - d2_q;
    c3 = c2 - d3_q;
    sc = (c3 <<< sdc_pkg::PRE_SHIFT) >>> shift;
  end

  // three integrators at the modulator rate
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      i1_q <= '0;
      i2_q <= '0;
      i3_q <= '0;
    end else if (bit_vld) begin
      i1_q <= i1_q + x;
      i2_q <= i2_q + i1_q;
      i3_q <= i3_q + i2_q;
    end
  end

  // comb delays and clipped output, updated once per decimation period
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      d1_q   <= '0;
      d2_q   <= '0;
      d3_q   <= '0;
      word_q <= '0;
    end else if (bit_vld && dec_vld) begin
      d1_q <= i3_n;
      d2_q <= c1;
      d3_q <= c2;
      if (sc > W'(signed'({1'b0, sdc_pkg::POS_CLIP})))
        word_q <= sdc_pkg::POS_CLIP;
      else if (sc < -W'(signed'({1'b0, sdc_pkg::POS_CLIP})) - W'(1))
        word_q <= sdc_pkg::NEG_CLIP;
      else
        word_q <= sc[sdc_pkg::DATA_W-1:0];
    end
  end
endmodule : sdc_chan
`default_nettype wire

// ===== verification/sdc_mod_model.sv
// modulator bitstream model for the eight channel inputs
// assumes strobe is the design's modulator sample strobe on clk
`timescale 1ns/1ps
`default_nettype none
module sdc_mod_model (
  input  wire logic       clk,      // converter clock
  input  wire logic       rst_n,    // sync reset, active low
  input  wire logic       strobe,   // modulator sample strobe
  input  wire logic       alt,      // 1 = alternating +1/-1 on all channels
  input  wire logic [7:0] pat,      // constant bit per channel when alt is 0
  output logic      [7:0] mod_bits  // bit per channel
);
  logic phase_q;
  // one new modulator bit per sample, changed on the sampling edge
  always_ff @(posedge clk) begin
    if (!rst_n) phase_q <= 1'b0;
    else if (strobe) phase_q <= ~phase_q;
  end
  // channel bits follow the chosen pattern
  assign mod_bits = alt ? {8{phase_q}} : pat;
endmodule : sdc_mod_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the sinc3 decimator and clock select
// assumes the modulator model file is compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         clk, rst_n, start, lp, sel, en, osc, ext, pin_i, buf_on, lvl, alt;
  logic [2:0]   dr;
  logic [7:0]   pat, bits;
  logic         pin_o, pin_oe, cclk, pd, v4, strobe, rdy;
  logic [191:0] data;
  logic [4:0]   eff;
  int           mismatches, n_tests, s, g;
  // clock pin level resolved from the design's drive and the outside source
  assign pin_i = pin_oe ? pin_o : ext;
  sdc_top dut (.clk(clk), .rst_n(rst_n), .start(start), .low_power(lp),
    .decimation_ratio_field(dr), .mod_bits(bits), .clock_source_select_pin(sel),
    .clk_out_en(en), .osc_in(osc), .clk_pin_i(pin_i), .reference_buffer_power_bit(buf_on),
    .reference_level_select(lvl), .clk_pin_o(pin_o), .clk_pin_oe(pin_oe), .conv_clk_q(cclk),
    .refbuf_pd_q(pd), .reference_level_select_q(v4), .mod_strobe_q(strobe), .data_ready_q(rdy),
    .data_q(data), .eff_bits_q(eff));
  sdc_mod_model model (.clk(clk), .rst_n(rst_n), .strobe(strobe), .alt(alt), .pat(pat),
    .mod_bits(bits));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  // counts modulator strobes until the next data-ready pulse
  task automatic to_ready(output int c);
    c = 0;
    for (int k = 0; k < 20000; k++) begin
      cyc(1);
      if (strobe === 1'b1) c++;
      if (rdy === 1'b1) break;
    end
  endtask : to_ready
  task automatic restart(input logic [2:0] f);
    start = 1'b0;
    cyc(2);
    dr = f;
    start = 1'b1;
  endtask : restart
  task automatic t_clock;
    for (int i = 0; i < 4; i++) begin
      {sel, en} = 2'(i);
      osc = 1'b1;
      ext = 1'b0;
      cyc(3);
      chk(pin_oe, sel & en);
      chk(cclk, sel);
      if (sel & en) chk(pin_o, 1'b1);
      osc = 1'b0;
      ext = 1'b1;
      cyc(3);
      chk(cclk, !sel);
      ext = 1'b0;
    end
  endtask : t_clock
  task automatic t_ref;
    for (int i = 0; i < 4; i++) begin
      {buf_on, lvl} = 2'(i);
      cyc(3);
      chk(pd, !buf_on);
      chk(v4, lvl);
    end
  endtask : t_ref
  task automatic t_rate;
    for (int m = 0; m < 2; m++) begin
      lp = m[0];
      for (int k = 0; k < 20 && strobe !== 1'b1; k++) cyc(1);
      s = 0;
      do begin
        cyc(1);
        s++;
      end while (strobe !== 1'b1 && s < 20);
      chk(s, m ? 8 : 4);
    end
    lp = 1'b0;
    start = 1'b0;
    cyc(2);
    s = 0;
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      if (strobe === 1'b1) s++;
    end
    chk(s, 0);
  endtask : t_rate
  task automatic t_eff;
    for (int f = 0; f < 8; f++) begin
      restart(3'(f));
      cyc(3);
      chk(eff, f == 0 ? 17 : f == 1 ? 19 : 24);
    end
  endtask : t_eff
  task automatic t_filter;
    pat = 8'h55;
    restart(3'h6);
    to_ready(s);
    chk(s, 48);
    for (g = 0; g < 8; g++) chk(data[24*g+:24], g[0] ? 24'h800000 : 24'h7FFFFF);
    dr = 3'h0;
    to_ready(s);
    chk(s, 16);
    alt = 1'b1;
    repeat (3) to_ready(s);
    chk(data[23:0], 24'h000000);
    alt = 1'b0;
    repeat (3) to_ready(s);
    chk(data[23:0], 24'h7FFFFF);
    pat = 8'hAA;
    restart(3'h6);
    cyc(3);
    chk(data[23:0], 24'h000000);
    to_ready(s);
    chk(s, 48);
    chk(data[23:0], 24'h800000);
    chk(data[47:24], 24'h7FFFFF);
  endtask : t_filter
  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // watchdog far beyond the expected run length
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
  initial begin
    {rst_n, start, lp, sel, en, osc, ext, buf_on, lvl, alt} = '0;
    dr = 3'h6;
    pat = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    cyc(1);
    chk(pd, 1'b1);
    chk(eff, 24);
    chk(rdy, 1'b0);
    chk(pin_oe, 1'b0);
    t_clock();
    t_ref();
    start = 1'b1;
    t_rate();
    t_eff();
    t_filter();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
